// ### cfg_decode_pkg.sv
// package: configuration word layouts, codes and decoded field structs
package cfg_decode_pkg;

  // ****************************************
  // register offsets (word index times four)
  // ****************************************
  localparam logic [3:0] OFF_CLOCK_WDOG = 4'h0;
  localparam logic [3:0] OFF_PLL_POWER = 4'h4;
  localparam logic [3:0] OFF_LOAD_STATUS = 4'h8;
  localparam logic [3:0] OFF_RUN_CTRL = 4'hC;
  localparam logic [31:0] CFG_WORD_RESET = 32'hFFFFFFFF;
  localparam logic [31:0] READ_ZERO = 32'h00000000;

  // ****************************************
  // word 1 field positions
  // ****************************************
  localparam int W1_RSVD_HI = 31;
  localparam int W1_RSVD_LO = 26;
  localparam int W1_WINSZ_HI = 25;
  localparam int W1_WINSZ_LO = 24;
  localparam int W1_WDOG_EN = 23;
  localparam int W1_WIN_DIS = 22;
  localparam int W1_STOP_PGM = 21;
  localparam int W1_WDPS_HI = 20;
  localparam int W1_WDPS_LO = 16;
  localparam int W1_CKSM_HI = 15;
  localparam int W1_CKSM_LO = 14;
  localparam int W1_PBDIV_HI = 13;
  localparam int W1_PBDIV_LO = 12;
  localparam int W1_RSVD_11 = 11;
  localparam int W1_CLOCK_OUTPUT_DIS = 10;
  localparam int W1_POSC_HI = 9;
  localparam int W1_POSC_LO = 8;
  localparam int W1_TWO_SPEED = 7;
  localparam int W1_RSVD_6 = 6;
  localparam int W1_SECONDARY_OSCILLATOR_EN = 5;
  localparam int W1_RSVD_4 = 4;
  localparam int W1_RSVD_3 = 3;
  localparam int W1_NOSC_HI = 2;
  localparam int W1_NOSC_LO = 0;

  // ****************************************
  // word 2 field positions
  // ****************************************
  localparam int W2_DS_EN = 31;
  localparam int W2_DSWD_EN = 30;
  localparam int W2_DSWD_CLK = 29;
  localparam int W2_DSPS_HI = 28;
  localparam int W2_DSPS_LO = 24;
  localparam int W2_DSBOR = 23;
  localparam int W2_RSVD_22 = 22;
  localparam int W2_RSVD_21 = 21;
  localparam int W2_BOR = 20;
  localparam int W2_RSVD_19 = 19;
  localparam int W2_ODIV_HI = 18;
  localparam int W2_ODIV_LO = 16;
  localparam int W2_UPLL_DIS = 15;
  localparam int W2_RSVD_HI = 14;
  localparam int W2_RSVD_LO = 11;
  localparam int W2_UIDIV_HI = 10;
  localparam int W2_UIDIV_LO = 8;
  localparam int W2_PLL_ICLK = 7;
  localparam int W2_MUL_HI = 6;
  localparam int W2_MUL_LO = 4;
  localparam int W2_RSVD_3 = 3;
  localparam int W2_IDIV_HI = 2;
  localparam int W2_IDIV_LO = 0;

  // ****************************************
  // codes and ratios
  // ****************************************
  localparam logic [4:0] WDPS_MAX = 5'h14;
  localparam logic [5:0] DSPS_BIAS = 6'h05;
  localparam logic [1:0] POSC_OFF = 2'h3;
  localparam logic [1:0] POSC_HS = 2'h2;
  localparam logic [1:0] POSC_XT = 2'h1;
  localparam logic [1:0] POSC_EC = 2'h0;
  localparam logic [2:0] NOSC_LOW_POWER_RC_OSC = 3'h5;
  localparam logic [2:0] NOSC_SECONDARY_OSCILLATOR = 3'h4;
  localparam logic [2:0] NOSC_POSC = 3'h2;
  localparam logic [2:0] NOSC_SYSTEM_PLL = 3'h1;
  localparam logic [2:0] NOSC_FRC = 3'h0;
  // window size in eighths of the period
  localparam logic [3:0] WIN_25 = 4'h2;
  localparam logic [3:0] WIN_37 = 4'h3;
  localparam logic [3:0] WIN_50 = 4'h4;
  localparam logic [3:0] WIN_75 = 4'h6;
  localparam logic [5:0] PBDIV_1 = 6'h00;
  localparam logic [5:0] PBDIV_2 = 6'h01;
  localparam logic [5:0] PBDIV_4 = 6'h03;
  localparam logic [5:0] PBDIV_8 = 6'h07;
  localparam logic [3:0] ODIV_SHIFT_MAX = 4'h8;

  typedef enum logic [3:0] {
    SRC_FRC = 4'h1,
    SRC_SYSTEM_PLL = 4'h2,
    SRC_POSC = 4'h4,
    SRC_OTHER = 4'h8
  } osc_src_t;

  typedef enum logic [2:0] {
    LD_RESET = 3'h1,
    LD_FETCH = 3'h2,
    LD_DONE = 3'h4
  } load_state_t;

  typedef struct packed {
    logic [3:0] window_eighths;
    logic wdog_running;
    logic wdog_windowed;
    logic wdog_halted;
    logic [4:0] wdog_shift;
  } wdog_cfg_t;

  typedef struct packed {
    logic sw_switch_allowed;
    logic failsafe_clock_monitor;
    logic [5:0] periph_bus_divider;
    logic clock_output_en;
    logic posc_on;
    logic posc_high_speed;
    logic posc_medium;
    logic posc_external;
    logic secondary_osc_on;
    logic [2:0] initial_osc_select;
    logic init_osc_reserved;
    logic [3:0] active_source;
  } clk_cfg_t;

  typedef struct packed {
    logic deep_sleep_entry;
    logic sleep_entry;
    logic dswdog_running;
    logic dswdog_low_power_rc_osc;
    logic [5:0] dswdog_shift;
    logic bor_active;
  } pwr_cfg_t;

  typedef struct packed {
    logic [3:0] odiv_shift;
    logic usb_pll_on;
    logic [3:0] usb_in_div;
    logic pll_from_frc;
    logic [4:0] pll_mul;
    logic [3:0] pll_in_div;
  } pll_cfg_t;

endpackage : cfg_decode_pkg

// ### boot_config_word_decoder.sv
// boot configuration word decoder: captures and decodes clock, watchdog and power words
`timescale 1ns/1ps
`default_nettype none
module boot_config_word_decoder
  import cfg_decode_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [31:0] nvm_word1,
  input wire logic [31:0] nvm_word2,
  input wire logic nvm_valid,
  input wire logic sw_wdog_enable,
  input wire logic flash_programming,
  input wire logic wait_executed,
  input wire logic posc_ready,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic cfg_loaded,
  output wdog_cfg_t wdog_cfg,
  output clk_cfg_t clk_cfg,
  output pwr_cfg_t pwr_cfg,
  output pll_cfg_t pll_cfg,
  output logic deep_sleep_req,
  output logic sleep_req,
  output logic reserved_fault
);

  // ****************************************
  // capture state
  // ****************************************
  load_state_t ld_state_r;
  load_state_t ld_state_nxt;
  logic [31:0] word1_r;
  logic [31:0] word2_r;
  logic sw_wdog_en_r;
  logic posc_switched_r;

  always_comb begin
    ld_state_nxt = ld_state_r;
    case (ld_state_r)
      LD_RESET: ld_state_nxt = LD_FETCH;
      LD_FETCH: begin
        if (nvm_valid) begin
          ld_state_nxt = LD_DONE;
        end
      end
      LD_DONE: ld_state_nxt = LD_DONE;
      default: ld_state_nxt = LD_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ld_state_r <= LD_RESET;
    end else begin
      ld_state_r <= ld_state_nxt;
    end
  end

  // words taken once after reset, frozen afterward
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      word1_r <= CFG_WORD_RESET;
      word2_r <= CFG_WORD_RESET;
    end else if (ld_state_r == LD_FETCH && nvm_valid) begin
      word1_r <= nvm_word1;
      word2_r <= nvm_word2;
    end
  end

  // ****************************************
  // run-time control register
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sw_wdog_en_r <= 1'b0;
    end else if (reg_wr && reg_addr == OFF_RUN_CTRL) begin
      sw_wdog_en_r <= reg_wdata[0];
    end
  end

  // ****************************************
  // field views
  // ****************************************
  logic [1:0] winsz;
  logic [4:0] wdps;
  logic [1:0] cksm;
  logic [1:0] pbdiv;
  logic [1:0] posc;
  logic [2:0] nosc;
  logic [2:0] odiv;
  logic [2:0] uidiv;
  logic [2:0] mul;
  logic [2:0] idiv;
  logic loaded;
  logic rsvd_ok;

  assign winsz = word1_r[W1_WINSZ_HI:W1_WINSZ_LO];
  assign wdps = word1_r[W1_WDPS_HI:W1_WDPS_LO];
  assign cksm = word1_r[W1_CKSM_HI:W1_CKSM_LO];
  assign pbdiv = word1_r[W1_PBDIV_HI:W1_PBDIV_LO];
  assign posc = word1_r[W1_POSC_HI:W1_POSC_LO];
  assign nosc = word1_r[W1_NOSC_HI:W1_NOSC_LO];
  assign odiv = word2_r[W2_ODIV_HI:W2_ODIV_LO];
  assign uidiv = word2_r[W2_UIDIV_HI:W2_UIDIV_LO];
  assign mul = word2_r[W2_MUL_HI:W2_MUL_LO];
  assign idiv = word2_r[W2_IDIV_HI:W2_IDIV_LO];
  assign loaded = (ld_state_r == LD_DONE);

  // reserved ones check
  assign rsvd_ok = (&word1_r[W1_RSVD_HI:W1_RSVD_LO]) && word1_r[W1_RSVD_11]
    && word1_r[W1_RSVD_6] && word1_r[W1_RSVD_4] && word1_r[W1_RSVD_3]
    && word2_r[W2_RSVD_22] && word2_r[W2_RSVD_21] && word2_r[W2_RSVD_19]
    && (&word2_r[W2_RSVD_HI:W2_RSVD_LO]) && word2_r[W2_RSVD_3];

  // ****************************************
  // decode functions
  // ****************************************
  function automatic logic [3:0] div_code(input logic [2:0] c);
    logic [3:0] v;
    v = 4'h1;
    case (c)
      3'h0: v = 4'h1;
      3'h1: v = 4'h2;
      3'h2: v = 4'h3;
      3'h3: v = 4'h4;
      3'h4: v = 4'h5;
      3'h5: v = 4'h6;
      3'h6: v = 4'hA;
      3'h7: v = 4'hC;
      default: v = 4'h1;
    endcase
    return v;
  endfunction : div_code

  function automatic logic [4:0] mul_code(input logic [2:0] c);
    logic [4:0] v;
    v = 5'h0F;
    case (c)
      3'h0: v = 5'h0F;
      3'h1: v = 5'h10;
      3'h2: v = 5'h11;
      3'h3: v = 5'h12;
      3'h4: v = 5'h13;
      3'h5: v = 5'h14;
      3'h6: v = 5'h15;
      3'h7: v = 5'h18;
      default: v = 5'h0F;
    endcase
    return v;
  endfunction : mul_code

  function automatic logic [3:0] odiv_code(input logic [2:0] c);
    logic [3:0] v;
    v = 4'h0;
    case (c)
      3'h0: v = 4'h0;
      3'h1: v = 4'h1;
      3'h2: v = 4'h2;
      3'h3: v = 4'h3;
      3'h4: v = 4'h4;
      3'h5: v = 4'h5;
      3'h6: v = 4'h6;
      3'h7: v = ODIV_SHIFT_MAX;
      default: v = 4'h0;
    endcase
    return v;
  endfunction : odiv_code

  // ****************************************
  // watchdog decode
  // ****************************************
  wdog_cfg_t wdog_nxt;
  always_comb begin
    wdog_nxt = '0;
    case (winsz)
      2'h3: wdog_nxt.window_eighths = WIN_25;
      2'h2: wdog_nxt.window_eighths = WIN_37;
      2'h1: wdog_nxt.window_eighths = WIN_50;
      default: wdog_nxt.window_eighths = WIN_75;
    endcase
    wdog_nxt.wdog_running = word1_r[W1_WDOG_EN] | sw_wdog_enable | sw_wdog_en_r;
    wdog_nxt.wdog_windowed = ~word1_r[W1_WIN_DIS];
    wdog_nxt.wdog_halted = word1_r[W1_STOP_PGM] & flash_programming;
    wdog_nxt.wdog_shift = (wdps > WDPS_MAX) ? WDPS_MAX : wdps;
    if (!loaded) begin
      wdog_nxt = '0;
    end
  end

  // ****************************************
  // clock decode
  // ****************************************
  clk_cfg_t clk_nxt;
  always_comb begin
    clk_nxt = '0;
    clk_nxt.sw_switch_allowed = ~cksm[1];
    clk_nxt.failsafe_clock_monitor = (cksm == 2'h0);
    case (pbdiv)
      2'h0: clk_nxt.periph_bus_divider = PBDIV_1;
      2'h1: clk_nxt.periph_bus_divider = PBDIV_2;
      2'h2: clk_nxt.periph_bus_divider = PBDIV_4;
      default: clk_nxt.periph_bus_divider = PBDIV_8;
    endcase
    clk_nxt.clock_output_en = ~word1_r[W1_CLOCK_OUTPUT_DIS]
      && (posc == POSC_OFF || posc == POSC_EC);
    clk_nxt.posc_on = (posc != POSC_OFF);
    clk_nxt.posc_high_speed = (posc == POSC_HS);
    clk_nxt.posc_medium = (posc == POSC_XT);
    clk_nxt.posc_external = (posc == POSC_EC);
    clk_nxt.secondary_osc_on = word1_r[W1_SECONDARY_OSCILLATOR_EN];
    clk_nxt.initial_osc_select = nosc;
    clk_nxt.init_osc_reserved = !(nosc == NOSC_LOW_POWER_RC_OSC || nosc == NOSC_SECONDARY_OSCILLATOR
      || nosc == NOSC_POSC || nosc == NOSC_SYSTEM_PLL || nosc == NOSC_FRC)
      || (nosc == NOSC_POSC && posc == POSC_OFF);
    // auto switch ignores the software switch lock
    if (word1_r[W1_TWO_SPEED] && nosc == NOSC_POSC && !posc_switched_r) begin
      clk_nxt.active_source = SRC_FRC;
    end else if (nosc == NOSC_POSC) begin
      clk_nxt.active_source = SRC_POSC;
    end else if (nosc == NOSC_SYSTEM_PLL) begin
      clk_nxt.active_source = SRC_SYSTEM_PLL;
    end else if (nosc == NOSC_FRC) begin
      clk_nxt.active_source = SRC_FRC;
    end else begin
      clk_nxt.active_source = SRC_OTHER;
    end
    if (!loaded) begin
      clk_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      posc_switched_r <= 1'b0;
    end else if (loaded && posc_ready && posc != POSC_OFF) begin
      posc_switched_r <= 1'b1;
    end
  end

  // ****************************************
  // power and pll decode
  // ****************************************
  pwr_cfg_t pwr_nxt;
  pll_cfg_t pll_nxt;
  always_comb begin
    pwr_nxt = '0;
    pwr_nxt.deep_sleep_entry = word2_r[W2_DS_EN];
    pwr_nxt.sleep_entry = ~word2_r[W2_DS_EN];
    pwr_nxt.dswdog_running = word2_r[W2_DSWD_EN] & word2_r[W2_DS_EN];
    pwr_nxt.dswdog_low_power_rc_osc = word2_r[W2_DSWD_CLK];
    pwr_nxt.dswdog_shift = {1'b0, word2_r[W2_DSPS_HI:W2_DSPS_LO]} + DSPS_BIAS;
    // deep sleep uses its own brownout bit
    pwr_nxt.bor_active = word2_r[W2_DS_EN] ? word2_r[W2_DSBOR] : word2_r[W2_BOR];
    if (!loaded) begin
      pwr_nxt = '0;
    end
  end

  always_comb begin
    pll_nxt = '0;
    pll_nxt.odiv_shift = odiv_code(odiv);
    pll_nxt.usb_pll_on = ~word2_r[W2_UPLL_DIS];
    pll_nxt.usb_in_div = div_code(uidiv);
    pll_nxt.pll_from_frc = word2_r[W2_PLL_ICLK];
    pll_nxt.pll_mul = mul_code(mul);
    pll_nxt.pll_in_div = div_code(idiv);
    if (!loaded) begin
      pll_nxt = '0;
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wdog_cfg <= '0;
    end else begin
      wdog_cfg <= wdog_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      clk_cfg <= '0;
    end else begin
      clk_cfg <= clk_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pwr_cfg <= '0;
    end else begin
      pwr_cfg <= pwr_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pll_cfg <= '0;
    end else begin
      pll_cfg <= pll_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg_loaded <= 1'b0;
    end else begin
      cfg_loaded <= loaded;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reserved_fault <= 1'b0;
    end else begin
      reserved_fault <= loaded & ~rsvd_ok;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      deep_sleep_req <= 1'b0;
      sleep_req <= 1'b0;
    end else begin
      deep_sleep_req <= loaded & wait_executed & word2_r[W2_DS_EN];
      sleep_req <= loaded & wait_executed & ~word2_r[W2_DS_EN];
    end
  end

  // ****************************************
  // register read port
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= READ_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        OFF_CLOCK_WDOG: reg_rdata <= word1_r;
        OFF_PLL_POWER: reg_rdata <= word2_r;
        OFF_LOAD_STATUS: reg_rdata <= {30'h0, ~rsvd_ok & loaded, loaded};
        OFF_RUN_CTRL: reg_rdata <= {31'h0, sw_wdog_en_r};
        default: reg_rdata <= READ_ZERO;
      endcase
    end else begin
      reg_rdata <= READ_ZERO;
    end
  end

endmodule : boot_config_word_decoder
`default_nettype wire

// ### cfg_nvm_model.sv
// partner model: nonvolatile memory holding the two configuration words
`timescale 1ns/1ps
`default_nettype none
module cfg_nvm_model #(
  parameter logic [3:0] LOAD_DLY = 4'h3
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [31:0] img1,
  input wire logic [31:0] img2,
  output logic [31:0] nvm_word1,
  output logic [31:0] nvm_word2,
  output logic nvm_valid
);
  // ****************************************
  // read-out delay after reset
  // ****************************************
  logic [3:0] cnt_r;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_r <= 4'h0;
    end else if (cnt_r != LOAD_DLY) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  assign nvm_valid = (cnt_r == LOAD_DLY);
  // words not yet valid show the inverse image
  assign nvm_word1 = nvm_valid ? img1 : ~img1;
  assign nvm_word2 = nvm_valid ? img2 : ~img2;
endmodule : cfg_nvm_model
`default_nettype wire

// ### boot_config_word_decoder_chk.sv
// checker: port relations of the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
module boot_config_word_decoder_chk
  import cfg_decode_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [31:0] nvm_word1,
  input wire logic [31:0] nvm_word2,
  input wire logic flash_programming,
  input wire logic wait_executed,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic cfg_loaded,
  input wire wdog_cfg_t wdog_cfg,
  input wire clk_cfg_t clk_cfg,
  input wire pwr_cfg_t pwr_cfg,
  input wire logic deep_sleep_req,
  input wire logic sleep_req
);
  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_RD_IDLE_ZERO: assert property (!$past(reg_rd) |-> reg_rdata == READ_ZERO)
    else $error("read data not zero outside read slot");
  AST_RD_WORD1: assert property (reg_rd && reg_addr == OFF_CLOCK_WDOG && cfg_loaded
    |=> reg_rdata == nvm_word1) else $error("word one read back wrong");
  AST_LOAD_HOLD: assert property (cfg_loaded |=> cfg_loaded)
    else $error("loaded flag dropped");
  AST_WDOG_SHIFT: assert property (cfg_loaded |-> wdog_cfg.wdog_shift ==
    ((nvm_word1[20:16] > WDPS_MAX) ? WDPS_MAX : nvm_word1[20:16])) else $error("postscale");
  AST_WINDOWED: assert property (cfg_loaded |-> wdog_cfg.wdog_windowed == !nvm_word1[22])
    else $error("window mode wrong");
  AST_PBDIV: assert property (cfg_loaded |-> clk_cfg.periph_bus_divider ==
    6'((7'h01 << nvm_word1[13:12]) - 7'h01)) else $error("bus divider wrong");
  AST_CLOCK_OUTPUT: assert property (cfg_loaded |-> clk_cfg.clock_output_en == (!nvm_word1[10] &&
    (nvm_word1[9:8] == POSC_OFF || nvm_word1[9:8] == POSC_EC))) else $error("clock out");
  AST_DS_SHIFT: assert property (cfg_loaded |-> pwr_cfg.dswdog_shift ==
    {1'b0, nvm_word2[28:24]} + DSPS_BIAS) else $error("deep sleep postscale wrong");
  AST_BOR: assert property (cfg_loaded |-> pwr_cfg.bor_active ==
    (nvm_word2[31] ? nvm_word2[23] : nvm_word2[20])) else $error("brownout select wrong");
  AST_DEEP_REQ: assert property (wait_executed && cfg_loaded && nvm_word2[31]
    |=> deep_sleep_req && !sleep_req) else $error("deep sleep request missing");
  AST_REQ_PULSE: assert property (!$past(wait_executed) |-> !deep_sleep_req && !sleep_req)
    else $error("sleep request without wait");
  AST_HALT: assert property (cfg_loaded && flash_programming && nvm_word1[21]
    |=> wdog_cfg.wdog_halted) else $error("watchdog not halted");
  COV_LOAD: cover property ($rose(cfg_loaded));
  COV_WAIT: cover property (cfg_loaded && wait_executed);
  COV_READ: cover property (reg_rd ##1 reg_rdata != READ_ZERO);
endmodule : boot_config_word_decoder_chk
bind boot_config_word_decoder boot_config_word_decoder_chk chk (.clk(clk), .rst_b(rst_b),
  .nvm_word1(nvm_word1), .nvm_word2(nvm_word2), .flash_programming(flash_programming),
  .wait_executed(wait_executed), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .cfg_loaded(cfg_loaded), .wdog_cfg(wdog_cfg), .clk_cfg(clk_cfg),
  .pwr_cfg(pwr_cfg), .deep_sleep_req(deep_sleep_req), .sleep_req(sleep_req));
`default_nettype wire

// ### testbench.sv
// testbench: loads configuration images and checks decoded fields and registers
`timescale 1ns/1ps
`default_nettype none
module testbench
  import cfg_decode_pkg::*;
;
  // ****************************************
  // signals and instances
  // ****************************************
  logic clk = 1'b0, rst_b = 1'b0, nvm_valid, sw_en = 1'b0, flash = 1'b0, wait_ex = 1'b0;
  logic posc_rdy = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, cfg_loaded, ds_req, sl_req, rsv_flt;
  logic [31:0] img1 = 32'h0, img2 = 32'h0, w1, w2, reg_wdata = 32'h0, reg_rdata;
  logic [3:0] reg_addr = 4'h0;
  wdog_cfg_t wd;
  clk_cfg_t ck;
  pwr_cfg_t pw;
  pll_cfg_t pl;
  int mismatches = 0, total_checks = 0;
  localparam logic [3:0] WINT [4] = '{WIN_75, WIN_50, WIN_37, WIN_25};
  localparam logic [5:0] PBT [4] = '{PBDIV_1, PBDIV_2, PBDIV_4, PBDIV_8};
  localparam logic [3:0] DIVT [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hA, 4'hC};
  localparam logic [4:0] MULT [8] = '{5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h18};
  always #12.5 clk = ~clk;
  cfg_nvm_model mem (.clk(clk), .rst_b(rst_b), .img1(img1), .img2(img2), .nvm_word1(w1),
    .nvm_word2(w2), .nvm_valid(nvm_valid));
  boot_config_word_decoder dut (.clk(clk), .rst_b(rst_b), .nvm_word1(w1), .nvm_word2(w2),
    .nvm_valid(nvm_valid), .sw_wdog_enable(sw_en), .flash_programming(flash),
    .wait_executed(wait_ex), .posc_ready(posc_rdy), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cfg_loaded(cfg_loaded), .wdog_cfg(wd), .clk_cfg(ck), .pwr_cfg(pw), .pll_cfg(pl),
    .deep_sleep_req(ds_req), .sleep_req(sl_req), .reserved_fault(rsv_flt));
  // ****************************************
  // helpers
  // ****************************************
  task automatic wrap_up();
    if (mismatches == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [31:0] mk1(input logic [2:0] i);
    logic [4:0] wp;
    wp = 5'(i * 3);
    return {6'h3F, i[1:0], i[0], i[1], i[2], wp, i[2:1], i[1:0], 1'b1, i[2], ~i[1:0],
      i[0], 1'b1, i[1], 2'b11, i};
  endfunction : mk1
  function automatic logic [31:0] mk2(input logic [2:0] i);
    logic [4:0] dp;
    dp = 5'(i * 4 + 3);
    return {i[0], i[1], i[2], dp, i[1], 2'b11, i[2], 1'b1, i, i[0], 4'hF, i, i[1], i, 1'b1, ~i};
  endfunction : mk2
  function automatic wdog_cfg_t ewd(input logic [31:0] w);
    wdog_cfg_t e;
    e.window_eighths = WINT[w[25:24]];
    e.wdog_running = w[23];
    e.wdog_windowed = ~w[22];
    e.wdog_halted = 1'b0;
    e.wdog_shift = (w[20:16] > WDPS_MAX) ? WDPS_MAX : w[20:16];
    return e;
  endfunction : ewd
  function automatic clk_cfg_t eck(input logic [31:0] w);
    clk_cfg_t e;
    logic [1:0] p;
    logic [2:0] n;
    p = w[9:8];
    n = w[2:0];
    e.sw_switch_allowed = ~w[15];
    e.failsafe_clock_monitor = (w[15:14] == 2'h0);
    e.periph_bus_divider = PBT[w[13:12]];
    e.clock_output_en = ~w[10] & (p == POSC_OFF | p == POSC_EC);
    e.posc_on = (p != POSC_OFF);
    e.posc_high_speed = (p == POSC_HS);
    e.posc_medium = (p == POSC_XT);
    e.posc_external = (p == POSC_EC);
    e.secondary_osc_on = w[5];
    e.initial_osc_select = n;
    e.init_osc_reserved = (n == 3'h3) | (n > NOSC_LOW_POWER_RC_OSC) | (n == NOSC_POSC & p == POSC_OFF);
    e.active_source = (n == NOSC_FRC) ? SRC_FRC : (n == NOSC_SYSTEM_PLL) ? SRC_SYSTEM_PLL :
      (n == NOSC_POSC) ? SRC_POSC : SRC_OTHER;
    return e;
  endfunction : eck
  function automatic pwr_cfg_t epw(input logic [31:0] w);
    return '{w[31], ~w[31], w[30] & w[31], w[29], {1'b0, w[28:24]} + DSPS_BIAS,
      w[31] ? w[23] : w[20]};
  endfunction : epw
  function automatic pll_cfg_t epl(input logic [31:0] w);
    return '{(w[18:16] == 3'h7) ? ODIV_SHIFT_MAX : {1'b0, w[18:16]}, ~w[15], DIVT[w[10:8]],
      w[7], MULT[w[6:4]], DIVT[w[2:0]]};
  endfunction : epl
  task automatic load(input logic [31:0] a, input logic [31:0] b);
    @(posedge clk);
    img1 <= a;
    img2 <= b;
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    for (int n = 0; n < 20; n++) begin
      @(negedge clk);
      if (cfg_loaded === 1'b1) return;
    end
    mismatches++;
    $display("Error t=%0t configuration load timed out", $time);
    wrap_up();
  endtask : load
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : wr
  // ****************************************
  // scenarios
  // ****************************************
  task automatic s_fields();
    for (int i = 0; i < 8; i++) begin
      load(mk1(3'(i)), mk2(3'(i)));
      chk(wd, ewd(img1));
      chk(ck, eck(img1));
      chk(pw, epw(img2));
      chk(pl, epl(img2));
      chk(rsv_flt, 1'b0);
      @(posedge clk);
      flash <= 1'b1;
      wait_ex <= 1'b1;
      @(posedge clk);
      flash <= 1'b0;
      wait_ex <= 1'b0;
      @(negedge clk);
      chk(wd.wdog_halted, img1[21]);
      chk({ds_req, sl_req}, {img2[31], ~img2[31]});
    end
  endtask : s_fields
  task automatic s_two_speed();
    @(posedge clk);
    posc_rdy <= 1'b0;
    load(mk1(3'h2) | 32'h0000_8080, mk2(3'h0));
    chk(ck.active_source, SRC_FRC);
    @(posedge clk);
    posc_rdy <= 1'b1;
    for (int n = 0; n < 10 && ck.active_source !== SRC_POSC; n++) begin
      @(negedge clk);
    end
    chk(ck.active_source, SRC_POSC);
    if (ck.active_source !== SRC_POSC) begin
      wrap_up();
    end
  endtask : s_two_speed
  task automatic s_regs();
    load(mk1(3'h0), mk2(3'h0));
    rd(OFF_CLOCK_WDOG, img1);
    rd(OFF_PLL_POWER, img2);
    rd(OFF_LOAD_STATUS, 32'h0000_0001);
    wr(OFF_CLOCK_WDOG, 32'h0000_0000);
    rd(OFF_CLOCK_WDOG, img1);
    rd(4'h6, READ_ZERO);
    wr(OFF_RUN_CTRL, 32'h0000_0001);
    chk(wd.wdog_running, 1'b1);
    rd(OFF_RUN_CTRL, 32'h0000_0001);
    wr(OFF_RUN_CTRL, 32'h0000_0000);
    chk(wd.wdog_running, 1'b0);
    @(posedge clk);
    sw_en <= 1'b1;
    repeat (3) @(negedge clk);
    chk(wd.wdog_running, 1'b1);
    @(posedge clk);
    sw_en <= 1'b0;
    load(mk1(3'h0) & 32'hFFFF_F7FF, mk2(3'h0));
    chk(rsv_flt, 1'b1);
    rd(OFF_LOAD_STATUS, 32'h0000_0003);
  endtask : s_regs
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    s_fields();
    s_two_speed();
    s_regs();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
